// file: logic/serial_pkg.sv
// Shared constants for the serial transceiver: register offsets, field positions, reset values.
// Assumes an 8-bit register port with byte offsets as listed here.
package serial_pkg;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h0B;
  localparam logic [7:0] OFF_CONTROL = 8'h0A;
  localparam logic [7:0] OFF_BAUD = 8'h09;
  localparam int ST_RX_DONE = 7;
  localparam int ST_TX_DONE = 6;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_FRAMING = 4;
  localparam int ST_OVERRUN = 3;
  localparam int CT_RX_IRQ = 7;
  localparam int CT_TX_IRQ = 6;
  localparam int CT_EMPTY_IRQ = 5;
  localparam int CT_RX_EN = 4;
  localparam int CT_TX_EN = 3;
  localparam int CT_NINE = 2;
  localparam int CT_RX_NINTH = 1;
  localparam int CT_TX_NINTH = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] VOTE_A = 4'h7;
  localparam logic [3:0] VOTE_B = 4'h8;
  localparam logic [3:0] VOTE_C = 4'h9;
endpackage : serial_pkg

// file: logic/serial_baud_tick.sv
// Baud divider producing one tick per sixteenth of a bit.
// Assumes the divisor comes from a register on the same clock.
`timescale 1ns/1ns
`default_nettype none
module serial_baud_tick (
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Divisor and tick.
  input wire logic [7:0] divisor,
  output logic tick
);
  logic [7:0] count;

  // A tick every divisor+1 clocks gives bit rate = clock / (16 * (divisor + 1)).
  always_ff @(posedge clock) begin
    if (srst) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else if (count >= divisor) begin
      count <= 8'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick <= 1'b0;
    end
  end

  AST_TICK_SPACING: assert property (@(posedge clock) disable iff (srst)
    tick && divisor == 8'h01 && $stable(divisor) |=> !tick ##1 tick)
    else $error("baud tick spacing wrong");
endmodule // serial_baud_tick
`default_nettype wire

// file: logic/serial_core.sv
// Serial transceiver: register port, receiver with majority vote, transmitter, three interrupt requests.
// Assumes RXD is asynchronous and a global interrupt enable and vector acknowledge come from the core.
// How it works
// - stop bit zero sets, one clears framing
// - character arriving over unread data is lost, raises overrun
// - overrun visible after data register read
// - successful transfer clears overrun
// - status bits 2..0 read zero
// - receive done raises request when enabled
// - transmit done raises request when enabled
// - buffer empty raises request when enabled
// - receiver disabled blocks three flags setting
// - disabling receiver keeps set flags
// - transmitter drains both characters before stopping
// - nine-bit mode carries nine data bits
// - control bit 1 holds received ninth
// - control bit 0 supplies transmitted ninth
// - bit rate clock over 16(divisor+1)
// - eight-bit readable writable divisor register
// - sixteen samples, vote 8-10, reject start
// - receive done set on transfer, read clears
// - buffer empty set at load, write clears
// - transmit done after stop bit only while receiver enabled, cleared
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`default_nettype none
module serial_core (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic SRST,
  // Register port.
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Interrupt system.
  input wire logic GLOBAL_IRQ_EN,
  input wire logic TX_DONE_ACK,
  output logic RX_DONE_IRQ,
  output logic TX_DONE_IRQ,
  output logic TX_EMPTY_IRQ,
  // Serial line.
  input wire logic RXD,
  output logic TXD,
  output logic TXD_OE
);
  import serial_pkg::*;

  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_BITS = 3'b100} rx_state_e;
  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SHIFT = 3'b010, TX_HOLD = 3'b100} tx_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and decode.
  logic [7:0] control;
  logic [7:0] baud;
  logic [7:0] rx_data;
  logic [8:0] tx_buffer;
  logic rx_done, tx_done, tx_empty, framing, overrun, overrun_pending;
  logic tick;

  wire wr_data = WR && ADDR == OFF_DATA;
  wire wr_status = WR && ADDR == OFF_STATUS;
  wire wr_control = WR && ADDR == OFF_CONTROL;
  wire wr_baud = WR && ADDR == OFF_BAUD;
  wire rd_data = RD && ADDR == OFF_DATA;
  wire nine = control[CT_NINE];
  wire rx_en = control[CT_RX_EN];
  wire tx_en = control[CT_TX_EN];
  wire [7:0] status_view = {rx_done, tx_done, tx_empty, framing, overrun, 3'b000};
  // The transmit ninth bit is write-only, so it reads back as zero.
  wire [7:0] control_view = {control[7:1], 1'b0};
  wire [7:0] read_mux = (ADDR == OFF_DATA) ? rx_data :
                        (ADDR == OFF_STATUS) ? status_view :
                        (ADDR == OFF_CONTROL) ? control_view :
                        (ADDR == OFF_BAUD) ? baud : 8'h00;

  serial_baud_tick u_baud (
    .clock(CLOCK),
    .srst(SRST),
    .divisor(baud),
    .tick(tick)
  );

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? read_mux : 8'h00;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      baud <= BAUD_RESET;
    end else if (wr_baud) begin
      baud <= WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver.
  logic rxd_meta, rxd_sync;
  rx_state_e rx_state;
  logic [3:0] rx_phase;
  logic [3:0] rx_count;
  logic [9:0] rx_shift;
  logic [2:0] votes;
  logic rx_load, rx_load_stop, rx_load_ninth;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      rxd_meta <= RXD;
      rxd_sync <= rxd_meta;
    end
  end

  wire vote = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);
  wire bit_end = tick && rx_phase == OVERSAMPLE_LAST;
  wire [3:0] rx_bits_total = nine ? 4'd10 : 4'd9;
  wire [9:0] rx_shift_next = {vote, rx_shift[9:1]};

  always_ff @(posedge CLOCK) begin
    if (SRST || !rx_en) begin
      rx_state <= RX_IDLE;
      rx_phase <= 4'h0;
      rx_count <= 4'h0;
      rx_shift <= 10'h000;
      votes <= 3'b000;
      rx_load <= 1'b0;
      rx_load_stop <= 1'b0;
      rx_load_ninth <= 1'b0;
    end else begin
      rx_load <= 1'b0;
      if (tick && (rx_phase == VOTE_A || rx_phase == VOTE_B || rx_phase == VOTE_C)) begin
        votes <= {rxd_sync, votes[2:1]};
      end
      if (tick && rx_state != RX_IDLE) begin
        rx_phase <= rx_phase + 4'h1;
      end
      unique case (rx_state)
        RX_IDLE: begin
          rx_phase <= 4'h1;
          if (tick && !rxd_sync) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (bit_end) begin
            rx_state <= vote ? RX_IDLE : RX_BITS;
            rx_count <= 4'h0;
          end
        end
        RX_BITS: begin
          if (bit_end) begin
            rx_count <= rx_count + 4'h1;
            if (rx_count == rx_bits_total - 4'd1) begin
              rx_state <= RX_IDLE;
              rx_load <= 1'b1;
              rx_load_stop <= vote;
              rx_load_ninth <= nine ? rx_shift[9] : 1'b0;
              rx_shift <= nine ? rx_shift : {1'b0, rx_shift[9:1]};
            end else begin
              rx_shift <= rx_shift_next;
            end
          end
        end
      endcase
    end
  end

  // The shifter right-aligns data bits; eight-bit frames take one extra shift.
  wire [7:0] rx_byte = nine ? rx_shift[8:1] : rx_shift[8:1];
  // Loads are gated by the receiver enable: a frame finishing on the edge that
  // disables the receiver must not set a flag afterwards.
  wire rx_take = rx_load && rx_en && (!rx_done || rd_data);
  wire rx_lost = rx_load && rx_en && rx_done && !rd_data;

  // The receiver enable reaches this block only through the load gating, so disabling it keeps the flags.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rx_data <= 8'h00;
      rx_done <= 1'b0;
      framing <= 1'b0;
      overrun <= 1'b0;
      overrun_pending <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_data <= rx_byte;
        rx_done <= 1'b1;
        framing <= !rx_load_stop;
        overrun <= 1'b0;
        overrun_pending <= 1'b0;
      end else if (rx_lost) begin
        // Lost character: flag waits until the held character is read.
        overrun_pending <= 1'b1;
      end else if (rd_data) begin
        rx_done <= 1'b0;
        overrun <= overrun_pending;
        overrun_pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register and receive ninth bit.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      control <= CONTROL_RESET;
    end else begin
      if (wr_control) begin
        control[7:2] <= WDATA[7:2];
        control[CT_TX_NINTH] <= WDATA[CT_TX_NINTH];
      end
      if (rx_take) begin
        control[CT_RX_NINTH] <= rx_load_ninth;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter.
  tx_state_e tx_state;
  logic [10:0] tx_shift;
  logic [3:0] tx_bits;
  logic [3:0] tx_phase;

  wire tx_bit_end = tick && tx_phase == OVERSAMPLE_LAST;
  wire tx_start = !tx_empty && (tx_en || tx_state != TX_IDLE);
  wire tx_frame_done = tx_state == TX_SHIFT && tx_bit_end && tx_bits == 4'd1;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      tx_state <= TX_IDLE;
      tx_shift <= 11'h7FF;
      tx_bits <= 4'h0;
      tx_phase <= 4'h0;
      TXD <= 1'b1;
      TXD_OE <= 1'b0;
      tx_done <= 1'b0;
      tx_empty <= 1'b1;
    end else begin
      if (tick) begin
        tx_phase <= tx_phase + 4'h1;
      end
      if (wr_data) begin
        tx_buffer <= {control[CT_TX_NINTH], WDATA};
        tx_empty <= 1'b0;
      end
      // The clear comes first so that a completion on the same edge wins and is never lost.
      if ((wr_status && WDATA[ST_TX_DONE]) || TX_DONE_ACK) begin
        tx_done <= 1'b0;
      end
      unique case (tx_state)
        TX_IDLE, TX_HOLD: begin
          if (tx_start && !wr_data) begin
            // Stop bit high, optional ninth, data LSB first, start bit low.
            tx_shift <= nine ? {1'b1, tx_buffer, 1'b0} : {2'b11, tx_buffer[7:0], 1'b0};
            tx_bits <= nine ? 4'd11 : 4'd10;
            tx_empty <= 1'b1;
            tx_state <= TX_SHIFT;
            tx_phase <= 4'h0;
          end else if (tx_state == TX_HOLD && tx_bit_end) begin
            tx_state <= TX_IDLE;
            tx_done <= rx_en ? 1'b1 : tx_done;
          end
        end
        TX_SHIFT: begin
          if (tx_bit_end) begin
            TXD <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_bits <= tx_bits - 4'h1;
            if (tx_frame_done) begin
              tx_state <= TX_HOLD;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
      TXD_OE <= tx_en || tx_state != TX_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt requests.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      RX_DONE_IRQ <= 1'b0;
      TX_DONE_IRQ <= 1'b0;
      TX_EMPTY_IRQ <= 1'b0;
    end else begin
      RX_DONE_IRQ <= GLOBAL_IRQ_EN && control[CT_RX_IRQ] && rx_done;
      TX_DONE_IRQ <= GLOBAL_IRQ_EN && control[CT_TX_IRQ] && tx_done;
      TX_EMPTY_IRQ <= GLOBAL_IRQ_EN && control[CT_EMPTY_IRQ] && tx_empty;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_STATUS_LOW: assert property (@(posedge CLOCK) disable iff (SRST) RD && ADDR == OFF_STATUS |=> RDATA[2:0] == 3'b000)
    else $error("status low bits not zero");
  AST_RX_IRQ: assert property (@(posedge CLOCK) disable iff (SRST)
    GLOBAL_IRQ_EN && control[CT_RX_IRQ] && rx_done |=> RX_DONE_IRQ)
    else $error("receive request missing");
  AST_TX_IRQ: assert property (@(posedge CLOCK) disable iff (SRST)
    $rose(TX_DONE_IRQ) |-> $past(tx_done) && $past(control[CT_TX_IRQ]))
    else $error("transmit request without cause");
  AST_EMPTY_IRQ: assert property (@(posedge CLOCK) disable iff (SRST)
    GLOBAL_IRQ_EN && control[CT_EMPTY_IRQ] && tx_empty |=> TX_EMPTY_IRQ)
    else $error("empty request missing");
  AST_RX_DIS: assert property (@(posedge CLOCK) disable iff (SRST) !rx_en && !framing |=> !framing)
    else $error("framing set while disabled");
  AST_RX_KEEP: assert property (@(posedge CLOCK) disable iff (SRST)
    $fell(rx_en) && !rd_data |=> framing == $past(framing) && overrun == $past(overrun))
    else $error("receive flags changed on disable");
  AST_EMPTY_CLR: assert property (@(posedge CLOCK) disable iff (SRST) wr_data |=> !tx_empty)
    else $error("buffer empty not cleared");
  AST_RD_CLR: assert property (@(posedge CLOCK) disable iff (SRST) rd_data && !rx_load |=> !rx_done)
    else $error("receive done not cleared");
  AST_IDLE_HIGH: assert property (@(posedge CLOCK) disable iff (SRST) tx_state == TX_IDLE |=> TXD)
    else $error("line not idle high");
  AST_BAUD_RW: assert property (@(posedge CLOCK) disable iff (SRST)
    wr_baud ##1 !wr_baud ##1 (RD && ADDR == OFF_BAUD) |=> RDATA == $past(WDATA, 3))
    else $error("divisor readback wrong");
  AST_OVR_CLR: assert property (@(posedge CLOCK) disable iff (SRST) rx_take |=> !overrun)
    else $error("overrun not cleared by transfer");
  AST_FRAMING: assert property (@(posedge CLOCK) disable iff (SRST)
    rx_take |=> framing == !$past(rx_load_stop))
    else $error("framing flag does not follow stop bit");
  AST_NINTH: assert property (@(posedge CLOCK) disable iff (SRST)
    rx_take && nine |=> control[CT_RX_NINTH] == $past(rx_load_ninth))
    else $error("received ninth bit not stored");
  AST_TX_DRAIN: assert property (@(posedge CLOCK) disable iff (SRST)
    tx_state == TX_HOLD && !tx_empty && !wr_data |=> tx_state == TX_SHIFT)
    else $error("transmitter stopped before buffer drained");
  COV_RX: cover property (@(posedge CLOCK) rx_load);
  COV_NINE: cover property (@(posedge CLOCK) rx_take && nine);
  COV_OVR: cover property (@(posedge CLOCK) $rose(overrun));
  COV_TXDONE: cover property (@(posedge CLOCK) $rose(tx_done));
endmodule // serial_core
`default_nettype wire

// file: tb/serial_peer.sv
// Remote serial peer: drives the receive line and captures frames from the transmit line.
// Assumes the caller passes the bit time in clocks and calls its tasks just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
  // Clock.
  input wire logic clock,
  // Serial lines.
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  ////////////////////////////////////////////////////////////
  // A zero stop bit is sent only when a framing fault is wanted.
  task automatic send(input logic [8:0] d, input int n, input logic stop, input int bt);
    @(posedge clock);
    for (int i = -1; i <= n; i++) begin
      rxd <= (i < 0) ? 1'b0 : (i == n) ? stop : d[i];
      repeat (bt) @(posedge clock);
    end
    rxd <= 1'b1;
    // One idle bit time lets the receiver hand the character over before the caller reads.
    repeat (bt) @(posedge clock);
  endtask
  // A short low pulse that the receiver must reject as noise.
  task automatic glitch(input int len, input int bt);
    @(posedge clock);
    rxd <= 1'b0;
    repeat (len) @(posedge clock);
    rxd <= 1'b1;
    repeat (bt) @(posedge clock);
  endtask
  // Bits are sampled mid-cell, so a wrong bit time shows up as shifted data.
  task automatic recv(output logic [8:0] d, output logic [1:0] se, input int n, input int bt);
    int w;
    d = '0;
    w = 0;
    while (txd !== 1'b0 && w < 4000) begin
      @(posedge clock);
      w++;
    end
    repeat (bt / 2) @(posedge clock);
    se[1] = txd;
    for (int i = 0; i < n; i++) begin
      repeat (bt) @(posedge clock);
      d[i] = txd;
    end
    repeat (bt) @(posedge clock);
    se[0] = txd;
  endtask
endmodule // serial_peer
`default_nettype wire

// file: tb/uart_control_status_baud_tb_top.sv
// Self-checking bench for the serial transceiver: register port tests and line traffic.
// Assumes the package, the design and the peer model are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
module uart_control_status_baud_tb_top;
  import serial_pkg::*;
  localparam int BT = 32;
  logic clock, srst, wr_s, rd_s, gie, ack, rxd, txd, txd_oe, rx_irq, tx_irq, empty_irq;
  logic [7:0] addr, wdata, rdata;
  logic [8:0] d;
  logic [1:0] se;
  int num_errors = 0;
  int num_checks = 0;
  serial_core u_dut (.CLOCK(clock), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .GLOBAL_IRQ_EN(gie), .TX_DONE_ACK(ack), .RX_DONE_IRQ(rx_irq), .TX_DONE_IRQ(tx_irq),
    .TX_EMPTY_IRQ(empty_irq), .RXD(rxd), .TXD(txd), .TXD_OE(txd_oe));
  serial_peer u_peer (.clock(clock), .txd(txd), .rxd(rxd));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clock);
    wr_s <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    #1 chk({1'b0, rdata}, {1'b0, exp});
  endtask
  task automatic irq_chk(input logic [2:0] exp);
    repeat (2) @(posedge clock);
    #1 chk({6'h00, rx_irq, tx_irq, empty_irq}, {6'h00, exp});
    @(posedge clock);
  endtask
  task automatic tx_chk(input logic [8:0] exp, input int n);
    u_peer.recv(d, se, n, BT);
    chk(d, exp);
    chk({7'h00, se}, 9'h001);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    wrap_up();
  end
  initial begin
    srst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    gie = 1'b0;
    ack = 1'b0;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    rc(OFF_STATUS, 8'h20);
    rc(OFF_CONTROL, CONTROL_RESET);
    rc(OFF_BAUD, BAUD_RESET);
    rc(8'h3F, 8'h00);
    chk({7'h00, txd, txd_oe}, 9'h002);
    wr(OFF_BAUD, 8'hA5);
    rc(OFF_BAUD, 8'hA5);
    wr(OFF_BAUD, 8'h01);
    wr(OFF_CONTROL, 8'hF8);
    irq_chk(3'h0);
    chk({8'h00, txd_oe}, 9'h001);
    gie <= 1'b1;
    irq_chk(3'h1);
    wr(OFF_DATA, 8'hA5);
    repeat (8) @(posedge clock);
    wr(OFF_DATA, 8'h3C);
    rc(OFF_STATUS, 8'h00);
    irq_chk(3'h0);
    wr(OFF_CONTROL, 8'hF0);
    tx_chk(9'h0A5, 8);
    chk({8'h00, txd_oe}, 9'h001);
    tx_chk(9'h03C, 8);
    repeat (2 * BT) @(posedge clock);
    rc(OFF_STATUS, 8'h60);
    irq_chk(3'h3);
    chk({8'h00, txd_oe}, 9'h000);
    ack <= 1'b1;
    @(posedge clock);
    ack <= 1'b0;
    rc(OFF_STATUS, 8'h20);
    u_peer.send(9'h03C, 8, 1'b1, BT);
    rc(OFF_STATUS, 8'hA0);
    irq_chk(3'h5);
    rc(OFF_DATA, 8'h3C);
    rc(OFF_STATUS, 8'h20);
    wr(OFF_CONTROL, 8'h00);
    u_peer.send(9'h055, 8, 1'b0, BT);
    rc(OFF_STATUS, 8'h20);
    wr(OFF_CONTROL, 8'h10);
    u_peer.send(9'h055, 8, 1'b0, BT);
    rc(OFF_STATUS, 8'hB0);
    wr(OFF_CONTROL, 8'h00);
    rc(OFF_STATUS, 8'hB0);
    rc(OFF_DATA, 8'h55);
    wr(OFF_CONTROL, 8'h10);
    u_peer.send(9'h0A6, 8, 1'b1, BT);
    rc(OFF_STATUS, 8'hA0);
    rc(OFF_DATA, 8'hA6);
    u_peer.glitch(4, BT);
    rc(OFF_STATUS, 8'h20);
    u_peer.send(9'h011, 8, 1'b1, BT);
    u_peer.send(9'h022, 8, 1'b1, BT);
    rc(OFF_STATUS, 8'hA0);
    rc(OFF_DATA, 8'h11);
    rc(OFF_STATUS, 8'h28);
    u_peer.send(9'h033, 8, 1'b1, BT);
    rc(OFF_STATUS, 8'hA0);
    rc(OFF_DATA, 8'h33);
    wr(OFF_CONTROL, 8'h1D);
    u_peer.send(9'h1C3, 9, 1'b1, BT);
    rc(OFF_CONTROL, 8'h1E);
    rc(OFF_DATA, 8'hC3);
    wr(OFF_DATA, 8'h5A);
    tx_chk(9'h15A, 9);
    repeat (2 * BT) @(posedge clock);
    rc(OFF_STATUS, 8'h60);
    wr(OFF_STATUS, 8'h40);
    rc(OFF_STATUS, 8'h20);
    wrap_up();
  end
endmodule // uart_control_status_baud_tb_top
`default_nettype wire
